// ---- shared/one_shot_defines.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef ONE_SHOT_DEFINES_SVH
`define ONE_SHOT_DEFINES_SVH
`define ADDR_CLK_GATE 4'h0
`define ADDR_PRESCALE 4'h1
`define ADDR_DLY_MODE 4'h2
`define ADDR_WID_MODE 4'h3
`define ADDR_DLY_RELOAD 4'h4
`define ADDR_WID_RELOAD 4'h5
`define ADDR_START 4'h6
`define ADDR_IRQ_STATUS 4'h7
`define ADDR_IRQ_MASK 4'h8
`define ADDR_OUT_STATE 4'h9
`define ADDR_STOP 4'hA
`define BIT_UNIT_EN 0
`define BIT_START_DLY 0
`define BIT_START_WID 1
`define MODE_RESET 16'h0008
`define RELOAD_RESET 16'hFFFF
`define CLK_GATE_RESET 8'h00
`define PRESCALE_RESET 16'h0000
`define DELAY_EXTRA 16'h0002
`define RIDX_MAX 4
`endif

// ---- shared/one_shot_pkg.sv ----
// types shared by the one-shot timer pair
package one_shot_pkg;
  typedef enum logic [2:0] {
    MODE_INTERVAL = 3'h0,
    MODE_CAPTURE = 3'h2,
    MODE_EVENT = 3'h3,
    MODE_ONE_COUNT = 3'h4,
    MODE_CAP_ONE = 3'h6
  } channel_op_mode_t;

  typedef enum logic [2:0] {
    TRIG_SOFTWARE = 3'h0,
    TRIG_EDGE = 3'h1,
    TRIG_BOTH_EDGES = 3'h2,
    TRIG_MASTER = 3'h4
  } start_trigger_select_t;

  typedef struct packed {
    logic [1:0] channelClockSelect;
    logic unused13;
    logic countSourceSelect;
    logic halfWidthSplit;
    logic [2:0] startTriggerSelect;
    logic [1:0] inputEdgeSelect;
    logic [1:0] unused5;
    logic [2:0] channelOpMode;
    logic startBehaviourBit;
  } mode_reg_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage : one_shot_pkg

// ---- rtl/timer_channel.sv ----
// one 16-bit timer channel: counter, trigger handling and mode decode
`timescale 1ns/1ps
module timer_channel
  import one_shot_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic countTick,
  input wire logic softStart,
  input wire logic stopReq,
  input wire logic pinEdge,
  input wire logic pinAnyEdge,
  input wire logic masterIrq,
  input wire mode_reg_t mode,
  input wire logic [WIDTH-1:0] reload,
  input wire logic [WIDTH-1:0] extra,
  output logic irq,
  output logic running,
  output logic [WIDTH-1:0] count
);
  logic [WIDTH-1:0] countQ, countD;
  logic runQ, runD;
  logic irqD;
  logic trig, hwTrig, tick, downMode;
  logic [WIDTH-1:0] loadVal, topVal;

  always_comb begin
    case (start_trigger_select_t'(mode.startTriggerSelect))
      TRIG_EDGE: hwTrig = pinEdge;
      TRIG_BOTH_EDGES: hwTrig = pinAnyEdge;
      TRIG_MASTER: hwTrig = masterIrq;
      default: hwTrig = 1'b0;
    endcase
  end

  assign trig = enable & (softStart | hwTrig);
  // count source: operation clock tick or pin valid edge
  assign tick = enable & (mode.countSourceSelect ? pinEdge : countTick);
  assign downMode = ~mode.channelOpMode[1] | mode.channelOpMode[0];
  // split mode truncates the reload to the low byte
  assign topVal = mode.halfWidthSplit ? {{(WIDTH-8){1'b0}}, reload[7:0]} : reload;
  // extra cycles model trigger-to-load latency of the delay channel
  assign loadVal = WIDTH'(topVal + extra);

  always_comb begin
    countD = countQ;
    runD = runQ;
    irqD = 1'b0;
    if (stopReq || !enable) begin
      runD = 1'b0;
    end else if (trig && (!runQ || (mode.channelOpMode == MODE_ONE_COUNT &&
                                    mode.startBehaviourBit))) begin
      runD = 1'b1;
      countD = downMode ? loadVal : '0;
      // start interrupt for interval/capture, or retrigger in one-count
      if (mode.startBehaviourBit && (mode.channelOpMode == MODE_INTERVAL ||
          mode.channelOpMode == MODE_CAPTURE || runQ)) begin
        irqD = 1'b1;
      end
    end else if (runQ && tick) begin
      if (downMode) begin
        if (countQ == '0) begin
          irqD = 1'b1;
          if (mode.channelOpMode[2]) begin
            runD = 1'b0;
          end else begin
            countD = topVal;
          end
        end else begin
          countD = WIDTH'(countQ - 1'b1);
        end
      end else begin
        countD = WIDTH'(countQ + 1'b1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      countQ <= '0;
      runQ <= 1'b0;
    end else begin
      countQ <= countD;
      runQ <= runD;
    end
  end

  // expiry shows in its tick cycle, so a slave loads on that same edge
  assign irq = irqD;
  assign running = runQ;
  assign count = countQ;
endmodule : timer_channel

// ---- rtl/one_shot_delay_pulse_timer.sv ----
// delayed one-shot pulse generator built from a delay and a width channel
`timescale 1ns/1ps
`include "one_shot_defines.svh"
// Functional notes
// - one write setting both start bits starts the delay channel and enables the width channel
// - delay channel raises interrupt after delay, then stops until next trigger
// - width channel starts on delay interrupt; pulse pin goes high then
// - width expiry raises interrupt and drops pin low until next delay interrupt
// - unit clock enable bit 0 gates the whole timer clock
// - 4-bit prescaler field selects system clock divided by two to the n
// - mode bits 15:14 pick operation clock 0, 2, 1 or 3
// - mode bit 12 counts operation clock or timer input pin edges
// - mode bits 10:8 choose software, pin edge, both edges or master start
// - mode bits 3:1 choose operating mode and counting direction
// - interval and capture: behaviour bit 1 gives start interrupt and output change
// - one-count: behaviour bit 1 accepts retrigger with interrupt, else ignored
// - width channel bit 11 selects 16-bit or 8-bit operation
// - delay to interrupt equals reload plus two count periods
// - pulse width equals width reload times count period
// - slave output set by master interrupt, cleared by own interrupt
module one_shot_delay_pulse_timer
  import one_shot_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int PRESCALE_BITS = 15
) (
  input wire logic clk,
  input wire logic rst,
  input wire reg_req_t regReq,
  output logic [15:0] regRdata,
  input wire logic delayTimerInput,
  input wire logic widthTimerInput,
  output logic pulseOutputPin,
  output logic pulseOutputEn,
  output logic irq
);
  logic [7:0] clkGate_q, clkGate_d;
  logic [15:0] prescale_q, prescale_d;
  mode_reg_t dlyMode_q, dlyMode_d, widMode_q, widMode_d;
  logic [WIDTH-1:0] dlyReload_q, dlyReload_d, widReload_q, widReload_d;
  logic [1:0] irqStatus_q, irqStatus_d, irqMask_q, irqMask_d;
  logic pulse_q, pulse_d;
  logic [15:0] rdata_q, rdata_d;
  logic [PRESCALE_BITS-1:0] div_q, div_d;
  logic [PRESCALE_BITS:0] divNext;
  logic [1:0] dlySync_q, widSync_q;
  logic dlyPrev_q, widPrev_q;
  logic unitEn;
  logic [3:0] opTick;
  logic dlyTick, widTick;
  logic dlyStart, widStart, dlyStop, widStop;
  logic dlyIrq, widIrq, dlyRun, widRun;
  logic [WIDTH-1:0] dlyCount, widCount;
  logic dlyRise, dlyFall, widRise, widFall;
  logic dlyEdge, widEdge;
  logic dlyEn_q, dlyEn_d, widEn_q, widEn_d;

  assign unitEn = clkGate_q[`BIT_UNIT_EN];

  // free-running divider; tick n is a one-cycle pulse at system_clock / 2^n
  assign divNext = {1'b0, div_q} + 1'b1;
  always_comb begin
    div_d = unitEn ? divNext[PRESCALE_BITS-1:0] : '0;
  end

  function automatic logic prescaleTick(input logic [3:0] sel,
                                        input logic [PRESCALE_BITS:0] nxt,
                                        input logic [PRESCALE_BITS-1:0] cur);
    logic [PRESCALE_BITS:0] carries;
    carries = nxt ^ {1'b0, cur};
    if (sel == 4'h0) begin
      prescaleTick = 1'b1;
    end else begin
      // tick when bit sel-1 carries out, i.e. every 2^sel cycles
      prescaleTick = carries[sel];
    end
  endfunction : prescaleTick

  // clocks 0..3 each use their own 4-bit prescale field; none is fixed
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_tick
      assign opTick[gi] = unitEn & prescaleTick(prescale_q[gi*4 +: 4], divNext, div_q);
    end
  endgenerate

  // field code 01 is clock 2 and 10 is clock 1
  function automatic logic pickTick(input logic [1:0] sel, input logic [3:0] t);
    case (sel)
      2'b00: pickTick = t[0];
      2'b01: pickTick = t[2];
      2'b10: pickTick = t[1];
      default: pickTick = t[3];
    endcase
  endfunction : pickTick

  assign dlyTick = pickTick(dlyMode_q.channelClockSelect, opTick);
  assign widTick = pickTick(widMode_q.channelClockSelect, opTick);

  // pin inputs are asynchronous; edge logic reads only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dlySync_q <= 2'b00;
      widSync_q <= 2'b00;
      dlyPrev_q <= 1'b0;
      widPrev_q <= 1'b0;
    end else begin
      dlySync_q <= {dlySync_q[0], delayTimerInput};
      widSync_q <= {widSync_q[0], widthTimerInput};
      dlyPrev_q <= dlySync_q[1];
      widPrev_q <= widSync_q[1];
    end
  end

  assign dlyRise = dlySync_q[1] & ~dlyPrev_q;
  assign dlyFall = ~dlySync_q[1] & dlyPrev_q;
  assign widRise = widSync_q[1] & ~widPrev_q;
  assign widFall = ~widSync_q[1] & widPrev_q;
  // edge select 00 falling, 01 rising, otherwise both
  assign dlyEdge = (dlyMode_q.inputEdgeSelect == 2'b00) ? dlyFall :
                   (dlyMode_q.inputEdgeSelect == 2'b01) ? dlyRise : (dlyRise | dlyFall);
  assign widEdge = (widMode_q.inputEdgeSelect == 2'b00) ? widFall :
                   (widMode_q.inputEdgeSelect == 2'b01) ? widRise : (widRise | widFall);

  // both start bits in one write enable both channels in the same cycle; only the delay channel is started
  assign dlyStart = regReq.wr && regReq.addr == `ADDR_START &&
                    regReq.wdata[`BIT_START_DLY];
  assign widStart = regReq.wr && regReq.addr == `ADDR_START &&
                    regReq.wdata[`BIT_START_WID];
  assign dlyStop = regReq.wr && regReq.addr == `ADDR_STOP && regReq.wdata[`BIT_START_DLY];
  assign widStop = regReq.wr && regReq.addr == `ADDR_STOP && regReq.wdata[`BIT_START_WID];

  // start bits enable a channel until its stop bit; the start edge itself counts
  always_comb begin
    dlyEn_d = dlyEn_q;
    widEn_d = widEn_q;
    if (dlyStop) begin
      dlyEn_d = 1'b0;
    end
    if (widStop) begin
      widEn_d = 1'b0;
    end
    if (dlyStart) begin
      dlyEn_d = 1'b1;
    end
    if (widStart) begin
      widEn_d = 1'b1;
    end
  end

  // delay channel adds two periods of latency to its reload
  timer_channel #(.WIDTH(WIDTH)) u_delay (
    .clk(clk),
    .rst(rst),
    .enable(unitEn & (dlyEn_q | dlyStart)),
    .countTick(dlyTick),
    .softStart(dlyStart),
    .stopReq(dlyStop),
    .pinEdge(dlyEdge),
    .pinAnyEdge(dlyRise | dlyFall),
    .masterIrq(1'b0),
    .mode(dlyMode_q),
    .reload(dlyReload_q),
    .extra(WIDTH'(`DELAY_EXTRA - 16'h0001)),
    .irq(dlyIrq),
    .running(dlyRun),
    .count(dlyCount)
  );

  // width channel is triggered by the delay interrupt as slave
  timer_channel #(.WIDTH(WIDTH)) u_width (
    .clk(clk),
    .rst(rst),
    .enable(unitEn & (widEn_q | widStart)),
    .countTick(widTick),
    .softStart(1'b0),
    .stopReq(widStop),
    .pinEdge(widEdge),
    .pinAnyEdge(widRise | widFall),
    .masterIrq(dlyIrq),
    .mode(widMode_q),
    .reload(widReload_q),
    .extra(WIDTH'(16'hFFFF)),
    .irq(widIrq),
    .running(widRun),
    .count(widCount)
  );

  // slave output: set by master interrupt, cleared by own; set wins
  // width is exact only if the width clock is no slower than the delay clock
  always_comb begin
    pulse_d = pulse_q;
    if (widIrq) begin
      pulse_d = 1'b0;
    end
    if (dlyIrq) begin
      pulse_d = 1'b1;
    end
  end

  // register file
  always_comb begin
    clkGate_d = clkGate_q;
    prescale_d = prescale_q;
    dlyMode_d = dlyMode_q;
    widMode_d = widMode_q;
    dlyReload_d = dlyReload_q;
    widReload_d = widReload_q;
    irqMask_d = irqMask_q;
    irqStatus_d = irqStatus_q;
    rdata_d = 16'h0000;
    if (regReq.wr) begin
      case (regReq.addr)
        `ADDR_CLK_GATE: clkGate_d = regReq.wdata[7:0];
        `ADDR_PRESCALE: prescale_d = regReq.wdata;
        `ADDR_DLY_MODE: dlyMode_d = mode_reg_t'(regReq.wdata);
        `ADDR_WID_MODE: widMode_d = mode_reg_t'(regReq.wdata);
        `ADDR_DLY_RELOAD: dlyReload_d = regReq.wdata[WIDTH-1:0];
        `ADDR_WID_RELOAD: widReload_d = regReq.wdata[WIDTH-1:0];
        `ADDR_IRQ_MASK: irqMask_d = regReq.wdata[1:0];
        default: ;
      endcase
    end
    if (regReq.rd) begin
      case (regReq.addr)
        `ADDR_CLK_GATE: rdata_d = {8'h00, clkGate_q};
        `ADDR_PRESCALE: rdata_d = prescale_q;
        `ADDR_DLY_MODE: rdata_d = dlyMode_q;
        `ADDR_WID_MODE: rdata_d = widMode_q;
        `ADDR_DLY_RELOAD: rdata_d = 16'(dlyReload_q);
        `ADDR_WID_RELOAD: rdata_d = 16'(widReload_q);
        `ADDR_START: rdata_d = {14'h0000, widRun, dlyRun};
        `ADDR_IRQ_STATUS: begin
          rdata_d = {14'h0000, irqStatus_q};
          irqStatus_d = 2'b00;
        end
        `ADDR_IRQ_MASK: rdata_d = {14'h0000, irqMask_q};
        `ADDR_OUT_STATE: rdata_d = {15'h0000, pulse_q};
        default: rdata_d = 16'h0000;
      endcase
    end
    // a new event in the clearing cycle survives the read
    irqStatus_d = irqStatus_d | {widIrq, dlyIrq};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clkGate_q <= `CLK_GATE_RESET;
      prescale_q <= `PRESCALE_RESET;
      dlyMode_q <= mode_reg_t'(`MODE_RESET);
      widMode_q <= mode_reg_t'(`MODE_RESET);
      dlyReload_q <= WIDTH'(`RELOAD_RESET);
      widReload_q <= WIDTH'(`RELOAD_RESET);
      irqStatus_q <= 2'b00;
      irqMask_q <= 2'b00;
      pulse_q <= 1'b0;
      rdata_q <= 16'h0000;
      div_q <= '0;
      dlyEn_q <= 1'b0;
      widEn_q <= 1'b0;
    end else begin
      clkGate_q <= clkGate_d;
      prescale_q <= prescale_d;
      dlyMode_q <= dlyMode_d;
      widMode_q <= widMode_d;
      dlyReload_q <= dlyReload_d;
      widReload_q <= widReload_d;
      irqStatus_q <= irqStatus_d;
      irqMask_q <= irqMask_d;
      pulse_q <= pulse_d;
      rdata_q <= rdata_d;
      div_q <= div_d;
      dlyEn_q <= dlyEn_d;
      widEn_q <= widEn_d;
    end
  end

  assign regRdata = rdata_q;
  assign pulseOutputPin = pulse_q;
  assign pulseOutputEn = 1'b1;
  assign irq = |(irqStatus_q & irqMask_q);
endmodule : one_shot_delay_pulse_timer

// ---- bench/one_shot_checker.sv ----
// port-level checks for the one-shot timer pair
`timescale 1ns/1ps
`include "one_shot_defines.svh"
module one_shot_checker
  import one_shot_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int PRESCALE_BITS = 15
) (
  input wire logic clk,
  input wire logic rst,
  input wire reg_req_t regReq,
  input wire logic [15:0] regRdata,
  input wire logic delayTimerInput,
  input wire logic widthTimerInput,
  input wire logic pulseOutputPin,
  input wire logic pulseOutputEn,
  input wire logic irq
);
  logic [15:0] presQ, wModeQ, widRelQ, highQ;
  logic [1:0] maskQ;
  logic gateQ;
  // shadows of what software wrote, so outputs can be tied to their cause
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      presQ <= `PRESCALE_RESET;
      wModeQ <= `MODE_RESET;
      widRelQ <= `RELOAD_RESET;
      maskQ <= 2'h0;
      gateQ <= 1'b0;
      highQ <= 16'h0000;
    end else begin
      highQ <= pulseOutputPin ? highQ + 16'h0001 : 16'h0000;
      if (regReq.wr && regReq.addr == `ADDR_PRESCALE) presQ <= regReq.wdata;
      if (regReq.wr && regReq.addr == `ADDR_WID_MODE) wModeQ <= regReq.wdata;
      if (regReq.wr && regReq.addr == `ADDR_WID_RELOAD) widRelQ <= regReq.wdata;
      if (regReq.wr && regReq.addr == `ADDR_IRQ_MASK) maskQ <= regReq.wdata[1:0];
      if (regReq.wr && regReq.addr == `ADDR_CLK_GATE) gateQ <= regReq.wdata[0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  pin_driven_a: assert property (pulseOutputEn) else $error("pin not driven");
  read_idle_a: assert property (!$past(regReq.rd) |-> regRdata == 16'h0000)
    else $error("read data outside read slot");
  unmapped_zero_a: assert property ($past(regReq.rd) && $past(regReq.addr) > `ADDR_STOP
    |-> regRdata == 16'h0000) else $error("unmapped read not zero");
  gate_upper_a: assert property ($past(regReq.rd) && $past(regReq.addr) == `ADDR_CLK_GATE
    |-> regRdata[15:8] == 8'h00) else $error("gate upper bits set");
  reload_read_a: assert property ($past(regReq.rd) && $past(regReq.addr) == `ADDR_WID_RELOAD
    |-> regRdata == widRelQ) else $error("width reload readback");
  mask_block_a: assert property (maskQ == 2'h0 |-> !irq) else $error("masked irq seen");
  rise_gated_a: assert property ($rose(pulseOutputPin) |-> gateQ)
    else $error("pulse with unit clock off");
  rise_irq_a: assert property ($rose(pulseOutputPin) && maskQ[0] |-> irq)
    else $error("pulse rise without delay irq");
  width_count_a: assert property ($fell(pulseOutputPin) && presQ == 16'h0000 && !wModeQ[11]
    |-> highQ == widRelQ) else $error("pulse width wrong");
endmodule : one_shot_checker
bind one_shot_delay_pulse_timer one_shot_checker #(.WIDTH(WIDTH), .PRESCALE_BITS(PRESCALE_BITS))
  one_shot_checker_i (.clk(clk), .rst(rst), .regReq(regReq), .regRdata(regRdata),
  .delayTimerInput(delayTimerInput), .widthTimerInput(widthTimerInput),
  .pulseOutputPin(pulseOutputPin), .pulseOutputEn(pulseOutputEn), .irq(irq));

// ---- bench/pulse_pin_partner.sv ----
// board side of the timer: trigger-driven delay input, pulled-down width input and a pulse width meter
`timescale 1ns/1ps
module pulse_pin_partner (
  input wire logic clk,
  input wire logic pulseOutputPin,
  input wire logic pulseOutputEn,
  input wire logic extTrig,
  output logic delayTimerInput,
  output logic widthTimerInput,
  output logic [15:0] widthSeen,
  output logic [15:0] pulseCount
);
  logic [15:0] highCnt = 16'h0000;
  // delay input follows the external trigger; width input sits on its pull-down
  assign delayTimerInput = extTrig;
  assign widthTimerInput = 1'b0;
  initial widthSeen = 16'h0000;
  initial pulseCount = 16'h0000;
  always @(posedge clk) begin
    if (pulseOutputEn && pulseOutputPin) begin
      highCnt <= highCnt + 16'h0001;
    end else begin
      if (highCnt != 16'h0000) begin
        widthSeen <= highCnt;
        pulseCount <= pulseCount + 16'h0001;
      end
      highCnt <= 16'h0000;
    end
  end
endmodule : pulse_pin_partner

// ---- bench/tb.sv ----
// self-checking bench for the delayed one-shot pulse timer
`timescale 1ns/1ps
`include "one_shot_defines.svh"
module tb
  import one_shot_pkg::*;
;
  localparam logic [15:0] WID = 16'h0004;
  logic clk = 1'b0;
  logic rst = 1'b1;
  reg_req_t regReq = '0;
  logic extTrig = 1'b0;
  logic [15:0] regRdata, widthSeen, pulseCount;
  logic delayTimerInput, widthTimerInput, pulseOutputPin, pulseOutputEn, irq;
  int fail_count = 0;
  int n_compared = 0;
  always #5 clk = ~clk;
  one_shot_delay_pulse_timer one_shot_delay_pulse_timer_i (.clk(clk), .rst(rst),
    .regReq(regReq), .regRdata(regRdata), .delayTimerInput(delayTimerInput),
    .widthTimerInput(widthTimerInput), .pulseOutputPin(pulseOutputPin),
    .pulseOutputEn(pulseOutputEn), .irq(irq));
  pulse_pin_partner pulse_pin_partner_i (.clk(clk), .pulseOutputPin(pulseOutputPin),
    .pulseOutputEn(pulseOutputEn), .extTrig(extTrig), .delayTimerInput(delayTimerInput),
    .widthTimerInput(widthTimerInput), .widthSeen(widthSeen), .pulseCount(pulseCount));
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    regReq <= '0;
  endtask : wr
  task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    regReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    regReq <= '0;
    #1;
    chk(regRdata, exp);
  endtask : rchk
  // start the delay channel and enable the width channel, time the pulse and meter its width
  task automatic shot(input logic [15:0] w, input logic dlyChk, input logic irqExp);
    int n;
    logic [15:0] pc;
    pc = pulseCount;
    n = 0;
    wr(`ADDR_START, 16'h0003);
    while (pulseOutputPin !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (dlyChk) chk(16'(n), 16'h0005 + `DELAY_EXTRA);
    chk({15'h0, irq}, {15'h0, irqExp});
    n = 0;
    while (pulseCount === pc && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(widthSeen, w);
    rchk(`ADDR_OUT_STATE, 16'h0000);
  endtask : shot
  task automatic t_regs();
    rchk(`ADDR_CLK_GATE, {8'h00, `CLK_GATE_RESET});
    rchk(`ADDR_PRESCALE, `PRESCALE_RESET);
    rchk(`ADDR_DLY_MODE, `MODE_RESET);
    rchk(`ADDR_WID_MODE, `MODE_RESET);
    rchk(`ADDR_DLY_RELOAD, `RELOAD_RESET);
    rchk(`ADDR_IRQ_MASK, 16'h0000);
    rchk(4'hF, 16'h0000);
    $display("regs test done");
  endtask : t_regs
  task automatic t_gate_off();
    wr(`ADDR_DLY_RELOAD, 16'h0005);
    wr(`ADDR_WID_RELOAD, WID);
    wr(`ADDR_WID_MODE, 16'h0408);
    wr(`ADDR_IRQ_MASK, 16'h0003);
    wr(`ADDR_START, 16'h0003);
    repeat (60) @(posedge clk);
    chk(pulseCount, 16'h0000);
    wr(`ADDR_STOP, 16'h0003);
    wr(`ADDR_CLK_GATE, 16'h0001);
    $display("gate test done");
  endtask : t_gate_off
  task automatic t_shot();
    shot(WID, 1'b1, 1'b1);
    rchk(`ADDR_IRQ_STATUS, 16'h0003);
    chk({15'h0, irq}, 16'h0000);
    repeat (40) @(posedge clk);
    rchk(`ADDR_IRQ_STATUS, 16'h0000);
    chk(pulseCount, 16'h0001);
    $display("shot test done");
  endtask : t_shot
  task automatic t_mask();
    wr(`ADDR_IRQ_MASK, 16'h0000);
    shot(WID, 1'b1, 1'b0);
    rchk(`ADDR_IRQ_STATUS, 16'h0003);
    wr(`ADDR_IRQ_MASK, 16'h0003);
    $display("mask test done");
  endtask : t_mask
  task automatic pin_pulse();
    @(posedge clk);
    extTrig <= 1'b1;
    repeat (3) @(posedge clk);
    extTrig <= 1'b0;
  endtask : pin_pulse
  // a rising pin edge restarts the idle delay channel; a stop blocks it
  task automatic t_pin();
    int n;
    logic [15:0] pc;
    wr(`ADDR_DLY_MODE, 16'h0148);
    shot(WID, 1'b1, 1'b1);
    pc = pulseCount;
    pin_pulse();
    n = 0;
    while (pulseCount === pc && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(pulseCount, pc + 16'h0001);
    chk(widthSeen, WID);
    rchk(`ADDR_IRQ_STATUS, 16'h0003);
    wr(`ADDR_STOP, 16'h0003);
    pin_pulse();
    repeat (40) @(posedge clk);
    chk(pulseCount, pc + 16'h0001);
    wr(`ADDR_DLY_MODE, `MODE_RESET);
    $display("pin test done");
  endtask : t_pin
  task automatic t_clock();
    logic [15:0] expW [4] = '{16'h0020, 16'h0008, 16'h0004, 16'h0010};
    // clock0 /8, clock1 full, clock2 /2, clock3 /4; delay on the slowest clock
    wr(`ADDR_PRESCALE, 16'h2103);
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_WID_MODE, {i[1:0], 14'h0408});
      shot(expW[i], 1'b0, 1'b1);
      rchk(`ADDR_IRQ_STATUS, 16'h0003);
    end
    wr(`ADDR_PRESCALE, 16'h0000);
    $display("clock test done");
  endtask : t_clock
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_gate_off();
    t_shot();
    t_mask();
    t_pin();
    t_clock();
    final_report();
  end
  initial begin
    #300000;
    fail_count++;
    final_report();
  end
endmodule : tb
